// ==== core/bank_ram.sv ====
// Data RAM whose low part doubles as the register banks
`include "mem_map_defines.svh"
module bank_ram (
  input wire logic clk,
  ram_if.store     r
);
  logic [7:0] mem [`RAM_DEPTH];
  logic [8:0] b_hi;

  assign b_hi = 9'(r.b_addr + 9'h001);

  // No reset: contents are undefined after power-up
  always_ff @(posedge clk) begin
    if (r.a_en) begin
      r.a_rdata <= mem[r.a_addr];
    end
    if (r.b_en) begin
      r.b_rdata <= {r.b_pair ? mem[b_hi] : 8'h00, mem[r.b_addr]};
    end
    if (r.b_en && r.b_we) begin
      mem[r.b_addr] <= r.b_wdata[7:0];
      if (r.b_pair) begin
        mem[b_hi] <= r.b_wdata[15:8];
      end
    end
    // Memory port written last so it wins a same-byte collision
    if (r.a_en && r.a_we) begin
      mem[r.a_addr] <= r.a_wdata;
    end
  end
endmodule

// ==== core/cpu_memory_map.sv ====
// Address decode, program counter, register banks and address trap
`include "mem_map_defines.svh"
module cpu_memory_map
  import mem_map_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        large_rom,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [15:0] mem_addr,
  input  wire logic [7:0]  mem_wdata,
  output logic             mem_ack,
  output logic [7:0]       mem_rdata,
  output logic             io_req,
  output logic             io_we,
  output logic             io_ext,
  output logic [15:0]      io_addr,
  output logic [7:0]       io_wdata,
  input  wire logic [7:0]  io_rdata,
  output logic [15:0]      rom_addr,
  input  wire logic [7:0]  rom_data,
  input  wire logic        fetch_req,
  output logic             fetch_ack,
  output logic [7:0]       fetch_data,
  input  wire pc_op_t      pc_op,
  input  wire logic [2:0]  pc_len,
  input  wire logic [7:0]  pc_disp,
  input  wire logic [15:0] pc_target,
  input  wire logic [3:0]  pc_index,
  output logic [15:0]      pc_value,
  input  wire logic        reg_req,
  input  wire logic        reg_we,
  input  wire logic        reg_pair,
  input  wire logic [2:0]  reg_idx,
  input  wire logic [15:0] reg_wdata,
  output logic             reg_ack,
  output logic [15:0]      reg_rdata,
  input  wire logic        bank_we,
  input  wire logic [3:0]  bank_wdata,
  output logic [3:0]       bank_select_field,
  input  wire logic        ag_req,
  input  wire ag_mode_t    ag_mode,
  input  wire logic [7:0]  ag_disp,
  output logic             ag_ack,
  output logic [15:0]      ag_addr,
  output logic             bus_error,
  output logic             reset_out,
  output logic             reset_oe,
  output logic             running
);
  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic region_t decode_region(input logic [15:0] a, input logic big);
    if (a <= `SFR_LAST) begin
      decode_region = REGION_SFR;
    end else if (a <= `RAM_LAST) begin
      decode_region = REGION_RAM;
    end else if (a >= `DBR_BASE && a <= `DBR_LAST) begin
      decode_region = REGION_DBR;
    end else if (a >= (big ? `ROM_BASE_LARGE : `ROM_BASE_SMALL)) begin
      decode_region = REGION_ROM;
    end else begin
      decode_region = REGION_NONE;
    end
  endfunction

  function automatic logic [15:0] sext8(input logic [7:0] d);
    sext8 = {{8{d[7]}}, d};
  endfunction

  // Register byte address inside the store for the current bank
  function automatic logic [8:0] bank_byte(input logic [3:0] bank, input logic [2:0] idx);
    bank_byte = {2'b00, bank, idx};
  endfunction

  typedef enum logic [2:0] {
    ST_STRAP, ST_VA_LO, ST_VA_HI, ST_VC_LO, ST_VC_HI, ST_RUN, ST_TRAP
  } core_state_t;

  typedef enum logic [1:0] {AGS_IDLE, AGS_RD1, AGS_RD2} ag_state_t;

  core_state_t state;
  ag_state_t   ag_state;
  ram_if       rif ();

  logic        big;
  logic [4:0]  vec_idx;
  logic [7:0]  vec_lo;
  logic [15:0] pc;
  logic [15:0] fptr;
  logic [4:0]  trap_cnt;
  region_t     req_region;
  logic        mem_take;
  logic        rom_rd_take;
  logic        fetch_take;
  logic        trap_hit;
  logic        reg_take;
  logic        ag_take;
  logic        m1_valid, m2_valid, m1_psw, m2_psw;
  region_t     m1_region, m2_region;
  logic [7:0]  m2_data;
  logic        f1_valid, f2_valid;
  logic        reg_p1;
  ag_mode_t    ag_mode_q;
  logic [7:0]  ag_disp_q;
  logic [15:0] ag_hl_q;
  logic [15:0] next_ag_addr;
  logic [15:0] jump_t;

  bank_ram u_store (
    .clk (clk),
    .r   (rif.store)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Request acceptance

  assign req_region  = decode_region(mem_addr, big);
  assign mem_take    = mem_req && state == ST_RUN;
  assign rom_rd_take = mem_take && !mem_we && req_region == REGION_ROM;
  // Data reads own the ROM port; a colliding fetch is simply not taken
  assign fetch_take  = fetch_req && state == ST_RUN && !rom_rd_take && pc_op == PC_HOLD;
  assign trap_hit    = fetch_take && decode_region(fptr, big) == REGION_RAM;
  assign ag_take     = ag_req && ag_state == AGS_IDLE && state == ST_RUN;
  assign reg_take    = reg_req && !ag_req && ag_state == AGS_IDLE;

  ////////////////////////////////////////////////////////////////////////////
  // Reset vector, vector tables and address trap sequencing

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state    <= ST_STRAP;
      big      <= 1'b0;
      vec_idx  <= `RESET_VEC_IDX;
      vec_lo   <= 8'h00;
      trap_cnt <= 5'h00;
    end else begin
      case (state)
        ST_STRAP: begin
          big     <= large_rom;
          vec_idx <= `RESET_VEC_IDX;
          state   <= ST_VA_LO;
        end
        ST_VA_LO: state <= ST_VA_HI;
        ST_VA_HI: state <= ST_VC_LO;
        ST_VC_LO: begin
          vec_lo <= rom_data;
          state  <= ST_VC_HI;
        end
        ST_VC_HI: state <= ST_RUN;
        ST_RUN: begin
          if (trap_hit) begin
            trap_cnt <= 5'(`TRAP_CYCLES - 1);
            state    <= ST_TRAP;
          end else if (pc_op == PC_VCALL) begin
            vec_idx <= {1'b0, pc_index};
            state   <= ST_VA_LO;
          end else if (pc_op == PC_IRQ) begin
            vec_idx <= 5'(`IRQ_VEC_BASE_IDX + {1'b0, pc_index});
            state   <= ST_VA_LO;
          end
        end
        ST_TRAP: begin
          if (trap_cnt == 5'h00) begin
            state <= ST_STRAP;
          end else begin
            trap_cnt <= trap_cnt - 5'h01;
          end
        end
        default: state <= ST_STRAP;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_error <= 1'b0;
      reset_out <= 1'b0;
      reset_oe  <= 1'b0;
      running   <= 1'b0;
    end else begin
      bus_error <= trap_hit;
      reset_oe  <= trap_hit || (state == ST_TRAP && trap_cnt != 5'h00);
      running   <= state == ST_VC_HI || (state == ST_RUN && !trap_hit &&
                   pc_op != PC_VCALL && pc_op != PC_IRQ);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // ROM port: vector reads first, then data reads, then fetches

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rom_addr <= 16'h0000;
    end else if (state == ST_VA_LO) begin
      rom_addr <= `VECTOR_AREA | {10'h000, vec_idx, 1'b0};
    end else if (state == ST_VA_HI) begin
      rom_addr <= rom_addr | 16'h0001;
    end else if (rom_rd_take) begin
      rom_addr <= mem_addr;
    end else if (fetch_take && !trap_hit) begin
      rom_addr <= fptr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Program counter and fetch pointer

  always_comb begin
    case (pc_op)
      PC_SHORT: jump_t = pc + {{11{pc_disp[4]}}, pc_disp[4:0]};
      PC_REL:   jump_t = pc + sext8(pc_disp);
      PC_ABS:   jump_t = pc_target;
      PC_PCALL: jump_t = `PAGE_CALL_BASE | {8'h00, pc_target[7:0]};
      default:  jump_t = pc;
    endcase
  end

  // Sums wrap over 16 bits; no page or bank edge is checked
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pc   <= 16'h0000;
      fptr <= 16'h0000;
    end else if (state == ST_VC_HI) begin
      pc   <= {rom_data, vec_lo} + `PC_LEAD;
      fptr <= {rom_data, vec_lo};
    end else if (state == ST_RUN && !trap_hit) begin
      case (pc_op)
        PC_STEP: pc <= pc + {13'h0000, pc_len};
        PC_SHORT, PC_REL, PC_ABS, PC_PCALL: begin
          pc   <= jump_t + `PC_LEAD;
          fptr <= jump_t;
        end
        default: begin
          if (fetch_take) begin
            fptr <= fptr + 16'h0001;
          end
        end
      endcase
    end
  end

  assign pc_value = pc;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      f1_valid   <= 1'b0;
      f2_valid   <= 1'b0;
      fetch_ack  <= 1'b0;
      fetch_data <= 8'h00;
    end else begin
      f1_valid  <= fetch_take && !trap_hit;
      f2_valid  <= f1_valid;
      fetch_ack <= f2_valid;
      if (f2_valid) begin
        fetch_data <= rom_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bank select

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bank_select_field <= `BANK_RESET;
    end else if (state == ST_TRAP) begin
      bank_select_field <= `BANK_RESET;
    end else if (bank_we && state == ST_RUN) begin
      bank_select_field <= bank_wdata;
    end else if (mem_take && mem_we && mem_addr == `PSW_ADDR) begin
      bank_select_field <= mem_wdata[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data memory access pipeline

  always_comb begin
    rif.a_en    = mem_take && req_region == REGION_RAM;
    rif.a_we    = mem_we;
    rif.a_addr  = 9'(mem_addr - `RAM_BASE);
    rif.a_wdata = mem_wdata;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      io_req   <= 1'b0;
      io_we    <= 1'b0;
      io_ext   <= 1'b0;
      io_addr  <= 16'h0000;
      io_wdata <= 8'h00;
    end else begin
      io_req <= mem_take && mem_addr != `PSW_ADDR &&
                (req_region == REGION_SFR || req_region == REGION_DBR);
      if (mem_take) begin
        io_we    <= mem_we;
        io_ext   <= req_region == REGION_DBR;
        io_addr  <= mem_addr;
        io_wdata <= mem_wdata;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      m1_valid  <= 1'b0;
      m2_valid  <= 1'b0;
      m1_psw    <= 1'b0;
      m2_psw    <= 1'b0;
      m1_region <= REGION_NONE;
      m2_region <= REGION_NONE;
      m2_data   <= 8'h00;
      mem_ack   <= 1'b0;
      mem_rdata <= 8'h00;
    end else begin
      m1_valid  <= mem_take;
      m1_psw    <= mem_addr == `PSW_ADDR;
      m1_region <= req_region;
      m2_valid  <= m1_valid;
      m2_psw    <= m1_psw;
      m2_region <= m1_region;
      m2_data   <= rif.a_rdata;
      mem_ack   <= m2_valid;
      if (m2_valid) begin
        case (m2_region)
          REGION_RAM: mem_rdata <= m2_data;
          REGION_ROM: mem_rdata <= rom_data;
          REGION_SFR, REGION_DBR: begin
            mem_rdata <= m2_psw ? {4'h0, bank_select_field} : io_rdata;
          end
          default: mem_rdata <= 8'h00;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register port and pointer address generation, sharing store port B

  always_comb begin
    rif.b_en    = 1'b0;
    rif.b_we    = 1'b0;
    rif.b_pair  = 1'b1;
    rif.b_addr  = bank_byte(bank_select_field, `REG_L);
    rif.b_wdata = 16'h0000;
    if (ag_state == AGS_IDLE && ag_take) begin
      rif.b_en = ag_mode != AG_DIRECT;
      case (ag_mode)
        AG_DE:   rif.b_addr = bank_byte(bank_select_field, `REG_E);
        AG_PC_A: begin
          rif.b_addr = bank_byte(bank_select_field, `REG_A);
          rif.b_pair = 1'b0;
        end
        default: rif.b_addr = bank_byte(bank_select_field, `REG_L);
      endcase
    end else if (ag_state == AGS_IDLE && reg_take) begin
      rif.b_en    = 1'b1;
      rif.b_we    = reg_we;
      rif.b_pair  = reg_pair;
      rif.b_addr  = bank_byte(bank_select_field, reg_pair ? {reg_idx[2:1], 1'b0} : reg_idx);
      rif.b_wdata = reg_wdata;
    end else if (ag_state == AGS_RD1 && ag_mode_q == AG_HL_C) begin
      rif.b_en   = 1'b1;
      rif.b_pair = 1'b0;
      rif.b_addr = bank_byte(bank_select_field, `REG_C);
    end else if (ag_state == AGS_RD1 && (ag_mode_q == AG_HL_INC || ag_mode_q == AG_HL_DEC)) begin
      rif.b_en    = 1'b1;
      rif.b_we    = 1'b1;
      rif.b_wdata = ag_mode_q == AG_HL_INC ? rif.b_rdata + 16'h0001 : rif.b_rdata - 16'h0001;
    end
  end

  always_comb begin
    case (ag_mode_q)
      AG_HL_DISP: next_ag_addr = rif.b_rdata + sext8(ag_disp_q);
      AG_HL_DEC:  next_ag_addr = rif.b_rdata - 16'h0001;
      AG_PC_A:    next_ag_addr = pc + {8'h00, rif.b_rdata[7:0]};
      default:    next_ag_addr = rif.b_rdata;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ag_state  <= AGS_IDLE;
      ag_mode_q <= AG_HL;
      ag_disp_q <= 8'h00;
      ag_hl_q   <= 16'h0000;
      ag_ack    <= 1'b0;
      ag_addr   <= 16'h0000;
    end else begin
      ag_ack <= 1'b0;
      case (ag_state)
        AGS_IDLE: begin
          if (ag_take && ag_mode == AG_DIRECT) begin
            ag_ack  <= 1'b1;
            ag_addr <= {8'h00, ag_disp};
          end else if (ag_take) begin
            ag_mode_q <= ag_mode;
            ag_disp_q <= ag_disp;
            ag_state  <= AGS_RD1;
          end
        end
        AGS_RD1: begin
          if (ag_mode_q == AG_HL_C) begin
            ag_hl_q  <= rif.b_rdata;
            ag_state <= AGS_RD2;
          end else begin
            ag_ack   <= 1'b1;
            ag_addr  <= next_ag_addr;
            ag_state <= AGS_IDLE;
          end
        end
        AGS_RD2: begin
          ag_ack   <= 1'b1;
          ag_addr  <= ag_hl_q + {8'h00, rif.b_rdata[7:0]};
          ag_state <= AGS_IDLE;
        end
        default: ag_state <= AGS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_p1    <= 1'b0;
      reg_ack   <= 1'b0;
      reg_rdata <= 16'h0000;
    end else begin
      reg_p1  <= ag_state == AGS_IDLE && reg_take;
      reg_ack <= reg_p1;
      if (reg_p1) begin
        reg_rdata <= rif.b_rdata;
      end
    end
  end
endmodule

// ==== core/mem_map_defines.svh ====
// Address map, field positions, reset values and timing counts
`ifndef MEM_MAP_DEFINES_SVH
`define MEM_MAP_DEFINES_SVH

`define ADDR_W           16
`define SFR_LAST         16'h003f
`define PSW_ADDR         16'h003f
`define RAM_BASE         16'h0040
`define RAM_LAST         16'h023f
`define BANK_AREA_LAST   16'h00bf
`define DIRECT_LAST      16'h00ff
`define DBR_BASE         16'h0f80
`define DBR_LAST         16'h0fff
`define ROM_BASE_SMALL   16'hc000
`define ROM_BASE_LARGE   16'ha000
`define VECTOR_AREA      16'hffc0
`define PAGE_CALL_BASE   16'hff00
`define RAM_DEPTH        512
`define RAM_AW           9

`define RESET_VEC_IDX    5'h1f
`define IRQ_VEC_BASE_IDX 5'h10
`define PC_LEAD          16'h0002

`define BANK_RESET       4'h0
`define BANK_W           4

`define REG_A            3'h0
`define REG_W            3'h1
`define REG_C            3'h2
`define REG_B            3'h3
`define REG_E            3'h4
`define REG_D            3'h5
`define REG_L            3'h6
`define REG_H            3'h7

`define CLK_PERIOD_NS    50
`define TRAP_RESET_NS    800
`define TRAP_CYCLES      ((`TRAP_RESET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ==== core/mem_map_pkg.sv ====
// Types shared by the memory map core, its checker and its bench
package mem_map_pkg;
  typedef enum logic [2:0] {
    REGION_SFR, REGION_RAM, REGION_DBR, REGION_ROM, REGION_NONE
  } region_t;

  typedef enum logic [2:0] {
    PC_HOLD, PC_STEP, PC_SHORT, PC_REL, PC_ABS, PC_VCALL, PC_PCALL, PC_IRQ
  } pc_op_t;

  typedef enum logic [2:0] {
    AG_HL, AG_HL_DISP, AG_HL_C, AG_HL_INC, AG_HL_DEC, AG_DE, AG_DIRECT, AG_PC_A
  } ag_mode_t;
endpackage

// ==== core/ram_if.sv ====
// Two-port link between the core and the shared RAM / register store
interface ram_if;
  logic        a_en;
  logic        a_we;
  logic [8:0]  a_addr;
  logic [7:0]  a_wdata;
  logic [7:0]  a_rdata;
  logic        b_en;
  logic        b_we;
  logic        b_pair;
  logic [8:0]  b_addr;
  logic [15:0] b_wdata;
  logic [15:0] b_rdata;

  modport core  (output a_en, a_we, a_addr, a_wdata, b_en, b_we, b_pair, b_addr, b_wdata,
                 input a_rdata, b_rdata);
  modport store (input a_en, a_we, a_addr, a_wdata, b_en, b_we, b_pair, b_addr, b_wdata,
                 output a_rdata, b_rdata);
endinterface

// ==== test/cpu_memory_map_properties.sv ====
// Concurrent checks on the memory map core's ports
module cpu_memory_map_checker
  import mem_map_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        mem_req,
  input wire logic        mem_ack,
  input wire logic        running,
  input wire pc_op_t      pc_op,
  input wire logic [2:0]  pc_len,
  input wire logic [15:0] pc_target,
  input wire logic [15:0] pc_value,
  input wire logic        bus_error,
  input wire logic        reset_oe,
  input wire logic        reset_out,
  input wire logic [3:0]  bank_select_field
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [4:0] oe_cnt;
  // Counts cycles the pin has been pulled low so far
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) oe_cnt <= 5'h00;
    else if (reset_oe) oe_cnt <= oe_cnt + 5'h01;
    else oe_cnt <= 5'h00;
  end
  ////////////////////////////////////////////////////////////////////////////////
  AST_ACK_DELAY: assert property (mem_req && running |-> ##3 mem_ack)
    else $error("memory answer not three cycles after request");
  AST_ACK_CAUSE: assert property (mem_ack |-> $past(mem_req && running, 3))
    else $error("memory answer without request");
  AST_PC_ABS: assert property (running && pc_op == PC_ABS |=>
    pc_value == $past(pc_target) + 16'h0002) else $error("absolute jump pc wrong");
  AST_PC_PCALL: assert property (running && pc_op == PC_PCALL |=>
    pc_value == {8'hff, $past(pc_target[7:0])} + 16'h0002) else $error("page call pc wrong");
  AST_PC_STEP: assert property (running && pc_op == PC_STEP |=>
    pc_value == $past(pc_value) + 16'($past(pc_len))) else $error("step pc wrong");
  AST_PIN_LEVEL: assert property (reset_out == 1'b0)
    else $error("reset pin driven high");
  AST_TRAP_START: assert property (bus_error |-> ##[0:2] reset_oe)
    else $error("bus error without pin reset");
  AST_TRAP_MAX: assert property (reset_oe |-> oe_cnt < 5'h10)
    else $error("pin reset too long");
  AST_TRAP_LEN: assert property ($fell(reset_oe) |-> oe_cnt == 5'h10)
    else $error("pin reset length wrong");
  AST_TRAP_QUIET: assert property (reset_oe && $past(reset_oe) |->
    !running && bank_select_field == 4'h0) else $error("core active during trap");
endmodule

bind cpu_memory_map cpu_memory_map_checker u_cpu_memory_map_checker (.clk, .rst_n, .mem_req,
  .mem_ack, .running, .pc_op, .pc_len, .pc_target, .pc_value, .bus_error, .reset_oe,
  .reset_out, .bank_select_field);

// ==== test/cpu_memory_map_regbanks_bench.sv ====
// Self-checking bench for the memory map core
module cpu_memory_map_regbanks_bench;
  import mem_map_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, large_rom, mem_req, mem_we, fetch_req, reg_req, reg_we, reg_pair;
  logic bank_we, ag_req, mem_ack, io_req, io_we, io_ext, fetch_ack, reg_ack, ag_ack;
  logic bus_error, reset_out, reset_oe, running;
  logic [15:0] mem_addr, pc_target, reg_wdata, io_addr, rom_addr, pc_value, reg_rdata;
  logic [15:0] ag_addr, a, rr, exp_pc;
  logic [7:0]  mem_wdata, pc_disp, ag_disp, mem_rdata, io_wdata, io_rdata, rom_data;
  logic [7:0]  fetch_data, rd, d;
  logic [2:0]  pc_len, reg_idx;
  logic [3:0]  pc_index, bank_wdata, bank_select_field;
  logic [5:0]  flags;
  logic [7:0]  exp_q[$];
  pc_op_t      pc_op;
  ag_mode_t    ag_mode;
  int          fail_count, checks, n;
  int unsigned seed = 8;
  assign flags = {fetch_ack, ag_ack, bus_error, running, reg_ack, mem_ack};

  cpu_memory_map u_cpu_memory_map (.clk, .rst_n, .large_rom, .mem_req, .mem_we, .mem_addr,
    .mem_wdata, .mem_ack, .mem_rdata, .io_req, .io_we, .io_ext, .io_addr, .io_wdata,
    .io_rdata, .rom_addr, .rom_data, .fetch_req, .fetch_ack, .fetch_data, .pc_op, .pc_len,
    .pc_disp, .pc_target, .pc_index, .pc_value, .reg_req, .reg_we, .reg_pair, .reg_idx,
    .reg_wdata, .reg_ack, .reg_rdata, .bank_we, .bank_wdata, .bank_select_field, .ag_req,
    .ag_mode, .ag_disp, .ag_ack, .ag_addr, .bus_error, .reset_out, .reset_oe, .running);
  rom_io_model u_rom_io_model (.clk, .rom_addr, .rom_data, .io_req, .io_addr, .io_rdata);

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  // Inputs always change 2 ns after the rising edge
  task automatic cyc(int k);
    repeat (k) @(posedge clk);
    #2;
  endtask
  task automatic wait_on(int w);
    for (int i = 0; i < 40 && flags[w] !== 1'b1; i++) cyc(1);
    if (flags[w] !== 1'b1) begin
      fail_count++;
      $display("MISMATCH wait %0d expected 1 seen timeout", w);
      wrap_up();
    end
  endtask
  task automatic mem(logic we, logic [15:0] ad, logic [7:0] wd);
    mem_req = 1'b1;
    mem_we = we;
    mem_addr = ad;
    mem_wdata = wd;
    cyc(1);
    mem_req = 1'b0;
    wait_on(0);
    rd = mem_rdata;
  endtask
  task automatic regx(logic we, logic pr, logic [2:0] ix, logic [15:0] wd);
    reg_req = 1'b1;
    reg_we = we;
    reg_pair = pr;
    reg_idx = ix;
    reg_wdata = wd;
    cyc(1);
    reg_req = 1'b0;
    wait_on(1);
    rr = reg_rdata;
  endtask
  task automatic pcop(pc_op_t op, logic [2:0] ln, logic [7:0] ds, logic [15:0] tg,
                      logic [15:0] nx, string what);
    pc_op = op;
    pc_len = ln;
    pc_disp = ds;
    pc_target = tg;
    cyc(1);
    pc_op = PC_HOLD;
    exp_pc = nx;
    chk(what, pc_value, exp_pc);
    cyc(1);
  endtask
  task automatic agx(ag_mode_t md, logic [7:0] ds, logic [15:0] ex, string what);
    ag_req = 1'b1;
    ag_mode = md;
    ag_disp = ds;
    cyc(1);
    ag_req = 1'b0;
    wait_on(4);
    chk(what, ag_addr, ex);
  endtask
  task automatic vec(pc_op_t op, logic [3:0] ix, logic [15:0] ex, string what);
    pc_op = op;
    pc_index = ix;
    cyc(1);
    pc_op = PC_HOLD;
    wait_on(2);
    chk(what, pc_value, ex);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_n, large_rom, mem_req, mem_we, fetch_req, reg_req, reg_we, reg_pair} = 8'h00;
    {bank_we, ag_req, bank_wdata, pc_index, reg_idx, pc_len} = 16'h0000;
    {mem_addr, pc_target, reg_wdata, mem_wdata, pc_disp, ag_disp} = 72'h0;
    pc_op = PC_HOLD;
    ag_mode = AG_HL;
    cyc(10);
    rst_n = 1'b1;
    wait_on(2);
    chk("reset pc", pc_value, 16'hc040);
    chk("reset bank", {12'h000, bank_select_field}, 16'h0000);
    $display("done: reset");
    for (n = 0; n < 6; n++) begin
      // Bank 0 is current here and stays untouched
      a = {8'h00, rnd()} + (n[0] ? 16'h0140 : 16'h0048);
      d = rnd();
      mem(1'b1, a, d);
      exp_q.push_back(d);
      mem(1'b0, a, 8'h00);
      chk("ram byte", {8'h00, rd}, {8'h00, exp_q.pop_front()});
    end
    mem(1'b1, 16'h0040, 8'ha5);
    regx(1'b0, 1'b0, 3'h0, 16'h0000);
    chk("bank0 accumulator", rr, 16'h00a5);
    regx(1'b1, 1'b1, 3'h0, 16'h1234);
    mem(1'b0, 16'h0041, 8'h00);
    chk("pair high byte", {8'h00, rd}, 16'h0012);
    mem(1'b0, 16'h0040, 8'h00);
    chk("pair low byte", {8'h00, rd}, 16'h0034);
    $display("done: ram and banks");
    mem(1'b1, 16'h003f, 8'h05);
    chk("bank field", {12'h000, bank_select_field}, 16'h0005);
    regx(1'b1, 1'b0, 3'h7, 16'h00c3);
    mem(1'b0, 16'h006f, 8'h00);
    chk("bank5 reg7 in ram", {8'h00, rd}, 16'h00c3);
    bank_we = 1'b1;
    bank_wdata = 4'ha;
    cyc(1);
    bank_we = 1'b0;
    chk("bank write", {12'h000, bank_select_field}, 16'h000a);
    d = rnd();
    mem(1'b0, {8'hd3, d}, 8'h00);
    chk("rom data", {8'h00, rd}, {8'h00, d ^ 8'hd3});
    mem(1'b0, 16'ha123, 8'h00);
    chk("rom absent", {8'h00, rd}, 16'h0000);
    mem(1'b0, 16'h0f80, 8'h00);
    chk("extended io", {8'h00, rd}, 16'h00da);
    chk("io space ext", {15'h0000, io_ext}, 16'h0001);
    mem(1'b0, 16'h0010, 8'h00);
    chk("special io", {8'h00, rd}, 16'h004a);
    chk("io space sfr", {15'h0000, io_ext}, 16'h0000);
    mem(1'b1, 16'h0010, 8'h66);
    chk("io write", {7'h00, io_we, io_wdata}, 16'h0166);
    $display("done: decode");
    // Pointer kept above the bank area, used like a stack
    regx(1'b1, 1'b1, 3'h6, 16'h0200);
    regx(1'b1, 1'b1, 3'h4, 16'h1357);
    regx(1'b1, 1'b1, 3'h2, 16'h0010);
    regx(1'b1, 1'b0, 3'h0, 16'h0007);
    d = rnd();
    agx(AG_HL_DISP, d, 16'h0200 + {{8{d[7]}}, d}, "hl disp");
    agx(AG_HL_C, 8'h00, 16'h0210, "hl plus c");
    agx(AG_DE, 8'h00, 16'h1357, "de pointer");
    agx(AG_PC_A, 8'h00, 16'hc047, "pc plus a");
    agx(AG_HL_DEC, 8'h00, 16'h01ff, "hl pre-dec");
    agx(AG_HL_INC, 8'h00, 16'h01ff, "hl post-inc");
    agx(AG_HL, 8'h00, 16'h0200, "hl pointer");
    agx(AG_DIRECT, 8'h9a, 16'h009a, "direct");
    $display("done: address generation");
    vec(PC_VCALL, 4'h3, 16'h383b, "vector call");
    vec(PC_IRQ, 4'h2, 16'h1a1d, "irq vector");
    pcop(PC_ABS, 3'h0, 8'h00, 16'hc235, 16'hc237, "pc abs");
    pcop(PC_REL, 3'h0, 8'h80, 16'h0000, exp_pc + 16'hff82, "pc rel");
    pcop(PC_SHORT, 3'h0, 8'h18, 16'h0000, exp_pc + 16'hfffa, "pc short");
    pcop(PC_STEP, 3'h3, 8'h00, 16'h0000, exp_pc + 16'h0003, "pc step");
    pcop(PC_PCALL, 3'h0, 8'h00, 16'h0012, 16'hff14, "pc page");
    fetch_req = 1'b1;
    cyc(1);
    fetch_req = 1'b0;
    wait_on(5);
    chk("page fetch", {8'h00, fetch_data}, 16'h00ed);
    pcop(PC_ABS, 3'h0, 8'h00, 16'h0040, 16'h0042, "pc into ram");
    $display("done: program counter");
    // Strap only takes effect at the reload after the trap
    large_rom = 1'b1;
    fetch_req = 1'b1;
    wait_on(3);
    fetch_req = 1'b0;
    n = 0;
    for (int i = 0; i < 60; i++) begin
      if (reset_oe === 1'b1) n++;
      cyc(1);
    end
    chk("trap pin cycles", 16'(n), 16'h0010);
    wait_on(2);
    chk("trap pc", pc_value, 16'hc040);
    chk("trap bank", {12'h000, bank_select_field}, 16'h0000);
    mem(1'b0, 16'ha123, 8'h00);
    chk("large rom", {8'h00, rd}, 16'h0082);
    $display("done: address trap");
    wrap_up();
  end
endmodule

// ==== test/rom_io_model.sv ====
// Synchronous program ROM and I/O register responder beside the core
module rom_io_model (
  input wire logic        clk,
  input wire logic [15:0] rom_addr,
  output logic     [7:0]  rom_data,
  input wire logic        io_req,
  input wire logic [15:0] io_addr,
  output logic     [7:0]  io_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  always @(posedge clk) begin
    if (rom_addr == 16'hfffe) rom_data <= 8'h3e;
    else if (rom_addr == 16'hffff) rom_data <= 8'hc0;
    else rom_data <= rom_addr[7:0] ^ rom_addr[15:8];
  end
  // Valid only the cycle after a request; toggles otherwise so stale reads show
  always @(posedge clk) io_rdata <= io_req ? (io_addr[7:0] ^ 8'h5a) : ~io_rdata;
endmodule
